// File: verilog/adc_fmt_pkg.sv
// constants, field layouts and carrier types for the converter result/select block
`default_nettype none
package adc_fmt_pkg;
	// ==========================================================
	// bus and register map (word index, byte address = 4 * index)
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int ADR_LSB = 2;
	localparam int BYTE_W = 8;
	localparam logic [5:0] IDX_CONTROL_B = 6'h03;
	localparam logic [5:0] IDX_RESULT_LOW = 6'h04;
	localparam logic [5:0] IDX_RESULT_HIGH = 6'h05;
	localparam logic [5:0] IDX_CONTROL_A = 6'h06;
	localparam logic [5:0] IDX_INPUT_SELECT = 6'h07;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h08;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h09;
	// ==========================================================
	// field positions
	localparam int CTLA_ENABLE_BIT = 7;
	localparam int CTLA_START_BIT = 6;
	localparam int CTLA_DONE_BIT = 4;
	localparam int CTLB_BIPOLAR_BIT = 4;
	localparam int IRQ_DONE_BIT = 0;
	localparam int REF_MSB = 7;
	localparam int REF_LSB = 6;
	localparam int GAIN_BIT = 0;
	localparam int RES_HIGH_MSB = 9;
	localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
	// ==========================================================
	// encodings
	localparam logic [1:0] REF_SUPPLY = 2'h0;
	localparam logic [1:0] REF_EXTERNAL = 2'h1;
	localparam logic [1:0] REF_INTERNAL = 2'h2;
	localparam logic [5:0] CH_TEMP_SENSOR = 6'h22;
	localparam logic [5:0] CH_SINGLE_LAST = 6'h07;
	localparam logic [5:0] CH_GROUND = 6'h20;
	localparam logic [5:0] CH_INTERNAL_REF = 6'h21;
	localparam logic [5:0] CH_DIFF_FIRST = 6'h08;
	localparam logic [5:0] CH_DIFF_LAST = 6'h1f;
	localparam logic [5:0] CH_REV_FIRST = 6'h23;
	// ==========================================================
	// result arithmetic
	localparam int RES_W = 10;
	localparam int CALC_W = 17;
	localparam logic [4:0] GAIN_HIGH = 5'h14;
	localparam logic [4:0] GAIN_UNITY = 5'h01;
	localparam logic signed [CALC_W-1:0] UNI_MAX = 17'sh003ff;
	localparam logic signed [CALC_W-1:0] BIP_MAX = 17'sh001ff;
	localparam logic signed [CALC_W-1:0] BIP_MIN = -17'sh00200;
	localparam logic signed [CALC_W-1:0] CALC_ZERO = 17'sh00000;
	// ==========================================================
	// timing in converter clock cycles, and the default count of system clocks per converter cycle
	localparam logic [4:0] CONV_NORMAL_CYCLES = 5'd13;
	localparam logic [4:0] CONV_EXTENDED_CYCLES = 5'd25;
	localparam int CONV_DIV_DEFAULT = 8;
	// ==========================================================
	// carriers
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONVERT = 2'b10
	} conv_state_t;
	typedef struct packed {
		logic [1:0] reference;
		logic [5:0] channel;
	} input_select_t;
	typedef struct packed {
		logic [1:0] ref_sel;
		logic [5:0] channel_gain_sel;
		logic gain_20x;
		logic temp_sensor_en;
		logic internal_ref_en;
		logic external_ref_en;
	} analog_ctrl_t;
endpackage
`default_nettype wire

// File: verilog/adc_result_format.sv
// converter control: input select, timing, result formatting, wishbone registers, interrupt
// =============================================================================
// How it works
// - done flag set means result bytes hold result
// - single-ended result is plain unsigned input code
// - unipolar differential scaled by gain, clamped at zero
// - bipolar differential two's complement, 0x200..0x1FF range
// - differential gain is one or twenty
// - top result bit is sign in bipolar
// - unipolar by default, bipolar bit selects bipolar
// - channel code 100010 enables temperature sensor channel
// - reference field decodes supply, external, internal
// - reference writes wait until conversion done
// - next conversion after reference change is extended
// - lowest channel bit selects gain one or twenty
// - normal conversion 13 cycles, extended 25 cycles
//
// Design decision made here: the Wishbone interface to the registers.
`default_nettype none
module adc_result_format #(
	parameter int CONV_DIV = adc_fmt_pkg::CONV_DIV_DEFAULT
) (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [adc_fmt_pkg::WB_AW-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [adc_fmt_pkg::WB_DW-1:0] WB_DAT_I,
	output logic [adc_fmt_pkg::WB_DW-1:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [adc_fmt_pkg::RES_W-1:0] POS_CODE,
	input wire logic [adc_fmt_pkg::RES_W-1:0] NEG_CODE,
	output adc_fmt_pkg::analog_ctrl_t ANALOG_CTRL,
	output logic CONV_BUSY,
	output logic CONV_EXTENDED,
	output logic IRQ
);
	import adc_fmt_pkg::*;

	localparam int DIV_W = $clog2(CONV_DIV + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
	localparam int PAD_W = CALC_W - RES_W;

	// =========================================================================
	// state
	typedef struct packed {
		conv_state_t st;
		logic enable;
		logic start;
		logic bipolar;
		input_select_t sel;
		input_select_t active;
		logic need_long;
		logic long_now;
		logic done;
		logic mask;
		logic [RES_W-1:0] result;
		logic [4:0] cyc;
		logic [DIV_W-1:0] div;
		logic ack;
		logic [WB_DW-1:0] rdata;
		logic irq;
		logic busy;
		analog_ctrl_t actl;
	} state_t;

	state_t s_reg;
	state_t s_next;

	logic bus_req;
	logic bus_wr;
	logic [5:0] idx;
	logic [7:0] wbyte;
	logic tick;
	logic last_cycle;
	logic is_diff;
	logic signed [CALC_W-1:0] diff;
	logic signed [CALC_W-1:0] scaled;
	logic signed [CALC_W-1:0] halved;
	logic [RES_W-1:0] formatted;
	logic [RES_W-1:0] next_result;
	logic done_set;
	logic done_clr;
	logic launch;

	// =========================================================================
	// result formatting from the analog front end codes
	always_comb begin
		// pairs, then offset calibration and reversed pairs above the sensor code
		is_diff = ((s_reg.active.channel >= CH_DIFF_FIRST)
			&& (s_reg.active.channel <= CH_DIFF_LAST))
			|| (s_reg.active.channel >= CH_REV_FIRST);
		diff = $signed({{PAD_W{1'b0}}, POS_CODE}) - $signed({{PAD_W{1'b0}}, NEG_CODE});
		// gain applied before the code is limited
		if (s_reg.active.channel[GAIN_BIT]) begin
			scaled = CALC_W'(diff * $signed({1'b0, GAIN_HIGH}));
		end else begin
			scaled = CALC_W'(diff * $signed({1'b0, GAIN_UNITY}));
		end
		halved = scaled >>> 1;
		if (!is_diff) begin
			formatted = POS_CODE;
		end else if (s_reg.bipolar) begin
			// two's complement, sign lands in the high byte
			if (halved > BIP_MAX) begin
				formatted = BIP_MAX[RES_W-1:0];
			end else if (halved < BIP_MIN) begin
				formatted = BIP_MIN[RES_W-1:0];
			end else begin
				formatted = halved[RES_W-1:0];
			end
		end else begin
			// negative difference saturates to zero
			if (scaled < CALC_ZERO) begin
				formatted = '0;
			end else if (scaled > UNI_MAX) begin
				formatted = UNI_MAX[RES_W-1:0];
			end else begin
				formatted = scaled[RES_W-1:0];
			end
		end
	end

	// =========================================================================
	// bus decode and converter clock enable
	always_comb begin
		// a request is taken once; the registered ack blocks a second take
		bus_req = WB_CYC_I && WB_STB_I && !s_reg.ack;
		// writes only act on the lowest byte lane
		bus_wr = bus_req && WB_WE_I && WB_SEL_I[0];
		idx = WB_ADR_I[WB_AW-1:ADR_LSB];
		wbyte = WB_DAT_I[BYTE_W-1:0];
		tick = (s_reg.div == DIV_LAST);
	end

	// =========================================================================
	// next state
	always_comb begin
		s_next = s_reg;
		last_cycle = 1'b0;
		done_set = 1'b0;
		done_clr = 1'b0;
		launch = 1'b0;
		next_result = s_reg.result;

		// =====================================================================
		// converter clock enable from the system clock
		// the divider only runs while converting, so idle draws no toggles
		if (s_reg.st != ST_CONVERT) begin
			s_next.div = '0;
		end else if (tick) begin
			s_next.div = '0;
		end else begin
			s_next.div = s_reg.div + 1'b1;
		end

		// =====================================================================
		// register writes
		s_next.ack = bus_req;
		if (bus_wr) begin
			unique case (idx)
				IDX_INPUT_SELECT: begin
					s_next.sel = input_select_t'(wbyte);
					if (wbyte[REF_MSB:REF_LSB] != s_reg.sel.reference) begin
						s_next.need_long = 1'b1;
					end
				end
				IDX_CONTROL_A: begin
					s_next.enable = wbyte[CTLA_ENABLE_BIT];
					// a start written while disabled is dropped, not remembered
					if (wbyte[CTLA_START_BIT] && wbyte[CTLA_ENABLE_BIT]) begin
						s_next.start = 1'b1;
					end
					// same sticky flop as the status bit, write one to clear
					if (wbyte[CTLA_DONE_BIT]) begin
						done_clr = 1'b1;
					end
				end
				IDX_CONTROL_B: begin
					s_next.bipolar = wbyte[CTLB_BIPOLAR_BIT];
				end
				IDX_IRQ_STATUS: begin
					if (wbyte[IRQ_DONE_BIT]) begin
						done_clr = 1'b1;
					end
				end
				IDX_IRQ_MASK: begin
					s_next.mask = wbyte[IRQ_DONE_BIT];
				end
				default: ;
			endcase
		end

		// =====================================================================
		// conversion sequencing
		unique case (s_reg.st)
			ST_IDLE: begin
				// idle: new selections apply at once
				s_next.active = s_next.sel;
				if (s_reg.start && s_reg.enable) begin
					launch = 1'b1;
					s_next.st = ST_CONVERT;
					s_next.cyc = '0;
					// a reference change taken at this very edge still counts
					s_next.long_now = s_next.need_long;
					s_next.need_long = 1'b0;
				end
			end
			ST_CONVERT: begin
				if (tick) begin
					s_next.cyc = s_reg.cyc + 1'b1;
					if (s_reg.long_now) begin
						last_cycle = (s_reg.cyc == CONV_EXTENDED_CYCLES - 1'b1);
					end else begin
						last_cycle = (s_reg.cyc == CONV_NORMAL_CYCLES - 1'b1);
					end
				end
				if (last_cycle) begin
					next_result = formatted;
					done_set = 1'b1;
					s_next.start = 1'b0;
					s_next.st = ST_IDLE;
					s_next.long_now = 1'b0;
					// pending selection takes effect only now
					s_next.active = s_next.sel;
				end
			end
			default: s_next.st = ST_IDLE;
		endcase

		// =====================================================================
		// turning the converter off aborts and forces the next one long
		if (!s_next.enable) begin
			s_next.st = ST_IDLE;
			s_next.start = 1'b0;
			s_next.long_now = 1'b0;
			s_next.need_long = 1'b1;
			s_next.active = s_next.sel;
		end

		s_next.result = next_result;
		// =====================================================================
		// status, interrupt and busy
		// an arriving done event beats a simultaneous clear
		if (done_set) begin
			s_next.done = 1'b1;
		end else if (done_clr) begin
			s_next.done = 1'b0;
		end
		// level interrupt, high while the unmasked sticky bit stands
		s_next.irq = s_next.done && s_next.mask;
		s_next.busy = (s_next.st == ST_CONVERT);

		// =====================================================================
		// analog controls follow the active selection only
		s_next.actl.ref_sel = s_next.active.reference;
		s_next.actl.channel_gain_sel = s_next.active.channel;
		s_next.actl.gain_20x = s_next.active.channel[GAIN_BIT];
		s_next.actl.temp_sensor_en = (s_next.active.channel == CH_TEMP_SENSOR);
		s_next.actl.internal_ref_en = (s_next.active.reference == REF_INTERNAL);
		s_next.actl.external_ref_en = (s_next.active.reference == REF_EXTERNAL);

		// =====================================================================
		// read data, sampled at request time
		s_next.rdata = '0;
		if (bus_req && !WB_WE_I) begin
			unique case (idx)
				IDX_INPUT_SELECT: begin
					s_next.rdata[BYTE_W-1:0] = s_reg.sel;
				end
				IDX_RESULT_LOW: begin
					s_next.rdata[BYTE_W-1:0] = s_reg.result[BYTE_W-1:0];
				end
				IDX_RESULT_HIGH: begin
					// upper bits stay zero from the default above
					s_next.rdata[RES_HIGH_MSB-BYTE_W:0] = s_reg.result[RES_W-1:BYTE_W];
				end
				IDX_CONTROL_A: begin
					s_next.rdata[CTLA_ENABLE_BIT] = s_reg.enable;
					s_next.rdata[CTLA_START_BIT] = s_reg.start;
					s_next.rdata[CTLA_DONE_BIT] = s_reg.done;
				end
				IDX_CONTROL_B: begin
					s_next.rdata[CTLB_BIPOLAR_BIT] = s_reg.bipolar;
				end
				IDX_IRQ_STATUS: begin
					s_next.rdata[IRQ_DONE_BIT] = s_reg.done;
				end
				IDX_IRQ_MASK: begin
					s_next.rdata[IRQ_DONE_BIT] = s_reg.mask;
				end
				default: ;
			endcase
		end
		if (launch) begin
			s_next.div = '0;
		end
	end

	// =========================================================================
	// registers
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.sel <= input_select_t'(INPUT_SELECT_RESET);
			s_reg.active <= input_select_t'(INPUT_SELECT_RESET);
			// first conversion after reset initialises the converter
			s_reg.need_long <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// =========================================================================
	// outputs, all taken from flops
	assign WB_DAT_O = s_reg.rdata;
	assign WB_ACK_O = s_reg.ack;
	assign ANALOG_CTRL = s_reg.actl;
	assign CONV_BUSY = s_reg.busy;
	assign CONV_EXTENDED = s_reg.long_now;
	assign IRQ = s_reg.irq;
endmodule
`default_nettype wire

// File: dv/adc_result_format_properties.sv
// assertion checker for the converter result and select block
`default_nettype none
module adc_result_format_properties #(
	parameter int CONV_DIV = adc_fmt_pkg::CONV_DIV_DEFAULT
) (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [adc_fmt_pkg::WB_AW-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [adc_fmt_pkg::WB_DW-1:0] WB_DAT_I,
	input wire logic [adc_fmt_pkg::WB_DW-1:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic [adc_fmt_pkg::RES_W-1:0] POS_CODE,
	input wire logic [adc_fmt_pkg::RES_W-1:0] NEG_CODE,
	input wire adc_fmt_pkg::analog_ctrl_t ANALOG_CTRL,
	input wire logic CONV_BUSY,
	input wire logic CONV_EXTENDED,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ns;
	import adc_fmt_pkg::*;
	// ==========
	// conversion span counter; one cycle of slack either way
	logic [7:0] span_reg;
	logic long_reg;
	logic abort_reg;
	logic [7:0] want;
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			span_reg <= 8'h00;
			long_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			span_reg <= CONV_BUSY ? span_reg + 8'h01 : 8'h00;
			long_reg <= CONV_EXTENDED;
			// a write that clears the enable bit cuts the conversion short
			abort_reg <= WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0]
				&& WB_ADR_I[7:2] == IDX_CONTROL_A && !WB_DAT_I[CTLA_ENABLE_BIT];
		end
	end
	assign want = 8'(long_reg ? CONV_EXTENDED_CYCLES * CONV_DIV : CONV_NORMAL_CYCLES * CONV_DIV);
	// ==========
	// properties
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);
	sequence s_taken;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_conv_end;
		$fell(CONV_BUSY);
	endsequence
	AST_ACK_NEXT:
	assert property (s_taken |=> WB_ACK_O)
		else $error("no ack one cycle after request");
	AST_ACK_PULSE:
	assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	AST_HIGH_BYTE:
	assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[7:2] == IDX_RESULT_HIGH |-> WB_DAT_O[31:2] == '0)
		else $error("result high byte upper bits set");
	AST_TEMP_ENABLE:
	assert property (ANALOG_CTRL.temp_sensor_en == (ANALOG_CTRL.channel_gain_sel == CH_TEMP_SENSOR))
		else $error("sensor enable wrong");
	AST_REF_DECODE:
	assert property (ANALOG_CTRL.internal_ref_en == (ANALOG_CTRL.ref_sel == REF_INTERNAL)
		&& ANALOG_CTRL.external_ref_en == (ANALOG_CTRL.ref_sel == REF_EXTERNAL))
		else $error("reference decode wrong");
	AST_GAIN_BIT:
	assert property (ANALOG_CTRL.channel_gain_sel inside {[CH_DIFF_FIRST:CH_DIFF_LAST]}
		|-> ANALOG_CTRL.gain_20x == ANALOG_CTRL.channel_gain_sel[GAIN_BIT])
		else $error("gain select wrong");
	AST_HOLD_SELECT:
	assert property (CONV_BUSY && $past(CONV_BUSY) |-> $stable(ANALOG_CTRL))
		else $error("select changed during conversion");
	AST_SELECT_APPLIES:
	assert property (s_taken ##0 (WB_WE_I && WB_SEL_I[0] && WB_ADR_I[7:2] == IDX_INPUT_SELECT
		&& !CONV_BUSY)
		|=> ##1 {ANALOG_CTRL.ref_sel, ANALOG_CTRL.channel_gain_sel} == $past(WB_DAT_I[7:0], 2))
		else $error("idle select write not applied");
	AST_LANE_IGNORED:
	assert property (s_taken ##0 (WB_WE_I && !WB_SEL_I[0] && WB_ADR_I[7:2] == IDX_INPUT_SELECT
		&& !CONV_BUSY) |=> $stable(ANALOG_CTRL))
		else $error("select write without lane zero applied");
	AST_CONV_LENGTH:
	assert property (s_conv_end ##0 !abort_reg |-> span_reg + 8'h01 >= want
		&& span_reg <= want + 8'h01)
		else $error("conversion length wrong");
	AST_EXT_IN_BUSY:
	assert property (CONV_EXTENDED |-> CONV_BUSY)
		else $error("extended flag outside conversion");
endmodule
bind adc_result_format adc_result_format_properties #(.CONV_DIV(CONV_DIV)) i_props (
	.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .POS_CODE(POS_CODE), .NEG_CODE(NEG_CODE),
	.ANALOG_CTRL(ANALOG_CTRL), .CONV_BUSY(CONV_BUSY), .CONV_EXTENDED(CONV_EXTENDED), .IRQ(IRQ)
);
`default_nettype wire

// File: dv/analog_front_model.sv
// behavioural analog front end with temperature sensor
`default_nettype none
module analog_front_model #(
	parameter logic [9:0] TEMP_CODE = 10'h12c
) (
	input wire adc_fmt_pkg::analog_ctrl_t ctrl,
	input wire logic [9:0] pin_pos,
	input wire logic [9:0] pin_neg,
	output logic [9:0] pos_code,
	output logic [9:0] neg_code
);
	timeunit 1ns;
	timeprecision 1ns;
	import adc_fmt_pkg::*;
	// ==========
	// sensor voltage only reaches the converter while enabled
	assign pos_code = ctrl.temp_sensor_en ? TEMP_CODE : pin_pos;
	// reserved reference: no valid code, so show a wrong one
	assign neg_code = (ctrl.ref_sel == 2'h3) ? ~pin_neg : pin_neg;
endmodule
`default_nettype wire

// File: dv/adc_result_format_test.sv
// self-checking bench for the converter result and select block
`default_nettype none
module adc_result_format_test;
	timeunit 1ns;
	timeprecision 1ns;
	import adc_fmt_pkg::*;
	localparam int DIV = 2;
	typedef struct {
		logic [7:0] ctlb;
		logic [7:0] sel;
		logic [9:0] pos;
		logic [9:0] neg;
		logic [9:0] res;
	} row_t;
	// control b, input select, positive code, negative code, result
	row_t rows [11] = '{
		'{8'h00, 8'h00, 10'h3ff, 10'h000, 10'h3ff},
		'{8'h00, 8'hc0, 10'h000, 10'h3ff, 10'h000},
		'{8'h00, 8'h08, 10'h100, 10'h040, 10'h0c0},
		'{8'h00, 8'h08, 10'h040, 10'h100, 10'h000},
		'{8'h00, 8'h09, 10'h030, 10'h010, 10'h280},
		'{8'h00, 8'h09, 10'h100, 10'h000, 10'h3ff},
		'{8'h10, 8'h08, 10'h000, 10'h3ff, 10'h200},
		'{8'h10, 8'h08, 10'h3ff, 10'h000, 10'h1ff},
		'{8'h10, 8'h08, 10'h100, 10'h140, 10'h3e0},
		'{8'h10, 8'h09, 10'h010, 10'h020, 10'h360},
		'{8'h10, 8'ha2, 10'h000, 10'h000, 10'h12c}
	};
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] lanes = 4'hf;
	logic [9:0] pin_pos = 10'h000;
	logic [9:0] pin_neg = 10'h000;
	logic [31:0] dat_o;
	logic [9:0] pos_code, neg_code;
	logic ack, busy, ext, irq, seen_ext;
	logic [7:0] q;
	analog_ctrl_t actrl;
	int failures = 0;
	int tests_run = 0;
	adc_result_format #(.CONV_DIV(DIV)) i_adc_result_format (
		.SYS_CLK(sys_clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(lanes), .WB_DAT_I(dat),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .POS_CODE(pos_code), .NEG_CODE(neg_code),
		.ANALOG_CTRL(actrl), .CONV_BUSY(busy), .CONV_EXTENDED(ext), .IRQ(irq)
	);
	analog_front_model i_analog_front_model (
		.ctrl(actrl), .pin_pos(pin_pos), .pin_neg(pin_neg),
		.pos_code(pos_code), .neg_code(neg_code)
	);
	// ==========
	// tasks
	task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= {24'h0, d};
		@(posedge sys_clk);
		while (ack !== 1'b1)
			@(posedge sys_clk);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_done();
		int n;
		for (n = 0; n < 99 && busy !== 1'b1; n++)
			@(posedge sys_clk);
		seen_ext = ext;
		for (n = 0; n < 99 && busy !== 1'b0; n++)
			@(posedge sys_clk);
		chk("finished", busy, 1'b0);
	endtask
	task automatic convert();
		bus(IDX_CONTROL_A, 1'b1, 8'hc0);
		wait_done();
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ==========
	// clock, watchdog, sequence
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		failures++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk("ctrl", 16'(actrl), 16'h0);
		bus(IDX_CONTROL_B, 1'b0, 8'h00);
		chk("bipolar", q[CTLB_BIPOLAR_BIT], 1'b0);
		bus(6'h3f, 1'b0, 8'h00);
		chk("unmapped", q, 8'h00);
		bus(IDX_IRQ_MASK, 1'b1, 8'h01);
		foreach (rows[i]) begin
			pin_pos <= rows[i].pos;
			pin_neg <= rows[i].neg;
			bus(IDX_CONTROL_B, 1'b1, rows[i].ctlb);
			bus(IDX_INPUT_SELECT, 1'b1, rows[i].sel);
			bus(IDX_INPUT_SELECT, 1'b0, 8'h00);
			chk("select", q, rows[i].sel);
			convert();
			bus(IDX_CONTROL_A, 1'b0, 8'h00);
			chk("done", q[CTLA_DONE_BIT], 1'b1);
			chk("irq", irq, 1'b1);
			bus(IDX_RESULT_LOW, 1'b0, 8'h00);
			chk("low", q, rows[i].res[7:0]);
			bus(IDX_RESULT_HIGH, 1'b0, 8'h00);
			chk("high", q, rows[i].res[9:8]);
			bus(IDX_IRQ_STATUS, 1'b1, 8'h01);
			chk("irq clear", irq, 1'b0);
		end
		bus(IDX_IRQ_MASK, 1'b1, 8'h00);
		convert();
		chk("normal", seen_ext, 1'b0);
		bus(IDX_IRQ_STATUS, 1'b0, 8'h00);
		chk("status", q[IRQ_DONE_BIT], 1'b1);
		chk("masked", irq, 1'b0);
		bus(IDX_IRQ_MASK, 1'b1, 8'h01);
		chk("unmasked", irq, 1'b1);
		bus(IDX_IRQ_STATUS, 1'b1, 8'h01);
		// reference written while converting
		bus(IDX_CONTROL_A, 1'b1, 8'hc0);
		bus(IDX_INPUT_SELECT, 1'b1, 8'h48);
		chk("held", actrl.ref_sel, REF_INTERNAL);
		wait_done();
		chk("applied", actrl.ref_sel, REF_EXTERNAL);
		convert();
		chk("extended", seen_ext, 1'b1);
		convert();
		chk("short again", seen_ext, 1'b0);
		bus(IDX_CONTROL_A, 1'b1, 8'h00);
		convert();
		chk("reenabled", seen_ext, 1'b1);
		// a write on the upper byte lanes alone is ignored
		lanes <= 4'he;
		bus(IDX_INPUT_SELECT, 1'b1, 8'h33);
		lanes <= 4'hf;
		bus(IDX_INPUT_SELECT, 1'b0, 8'h00);
		chk("lane", q, 8'h48);
		// mid-run reset clears the select and forces a long first conversion
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		bus(IDX_INPUT_SELECT, 1'b0, 8'h00);
		chk("select reset", q, INPUT_SELECT_RESET);
		convert();
		chk("reset extended", seen_ext, 1'b1);
		complete_run();
	end
endmodule
`default_nettype wire
